// >>> design/rvm_pkg.sv
// package of constants, register map and lookups for the regulator voltage monitor
`default_nettype none
package rvm_pkg;
  // channel count: five switchers then two linear regulators
  localparam int NUM_SW = 5;
  localparam int NUM_LDO = 2;
  localparam int NUM_CH = NUM_SW + NUM_LDO;

  // timing: bus clock and the low-power logic clock
  localparam int PCLK_PERIOD_NS = 20;
  localparam int LF_CLK_KHZ = 100;
  localparam int LF_PERIOD_NS = 1000000 / LF_CLK_KHZ;
  localparam logic [8:0] TICK_DIV = 9'(LF_PERIOD_NS / PCLK_PERIOD_NS - 1);

  // debounce times in microseconds, as selected by code 00..11
  localparam int UV_DB0_US = 5;
  localparam int UV_DB1_US = 15;
  localparam int UV_DB2_US = 25;
  localparam int UV_DB3_US = 40;
  localparam int OV_DB0_US = 30;
  localparam int OV_DB1_US = 50;
  localparam int OV_DB2_US = 80;
  localparam int OV_DB3_US = 125;

  // threshold percentages, code 00..11
  localparam logic [6:0] UV_PCT0 = 7'd95;
  localparam logic [6:0] UV_PCT1 = 7'd93;
  localparam logic [6:0] UV_PCT2 = 7'd91;
  localparam logic [6:0] UV_PCT3 = 7'd89;
  localparam logic [6:0] OV_PCT0 = 7'd105;
  localparam logic [6:0] OV_PCT1 = 7'd107;
  localparam logic [6:0] OV_PCT2 = 7'd109;
  localparam logic [6:0] OV_PCT3 = 7'd111;

  // register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_ENABLE = 8'h04;
  localparam logic [7:0] OFS_KEY = 8'h08;
  localparam logic [7:0] OFS_STATUS = 8'h0C;
  localparam logic [7:0] OFS_EVENT = 8'h10;
  localparam logic [7:0] OFS_CHCFG0 = 8'h20;
  localparam logic [7:0] OFS_CHCFG6 = 8'h38;

  // field positions
  localparam int CTRL_UVDB_LSB = 0;
  localparam int CTRL_OVDB_LSB = 2;
  localparam int CTRL_SECURE_BIT = 8;
  localparam int STAT_OV_LSB = 8;
  localparam int STAT_MASK_LSB = 16;
  localparam int CFG_UVSEL_LSB = 16;
  localparam int CFG_OVSEL_LSB = 18;

  // reset values
  localparam logic [1:0] UV_DB_RST = 2'h2;
  localparam logic [1:0] OV_DB_RST = 2'h0;
  localparam logic [6:0] ENABLE_RST = 7'h7F;
  localparam logic [15:0] NOMINAL_RST = 16'h0708;
  localparam logic [31:0] UNLOCK_KEY = 32'h0000_A5C3;

  // least time rounded up to whole low-clock ticks
  function automatic logic [3:0] to_ticks(input int us);
    return 4'((us * LF_CLK_KHZ + 999) / 1000);
  endfunction

  // undervoltage debounce code to ticks
  function automatic logic [3:0] uv_db_ticks(input logic [1:0] sel);
    case (sel)
      2'h0: return to_ticks(UV_DB0_US);
      2'h1: return to_ticks(UV_DB1_US);
      2'h2: return to_ticks(UV_DB2_US);
      default: return to_ticks(UV_DB3_US);
    endcase
  endfunction

  // overvoltage debounce code to ticks
  function automatic logic [3:0] ov_db_ticks(input logic [1:0] sel);
    case (sel)
      2'h0: return to_ticks(OV_DB0_US);
      2'h1: return to_ticks(OV_DB1_US);
      2'h2: return to_ticks(OV_DB2_US);
      default: return to_ticks(OV_DB3_US);
    endcase
  endfunction

  // threshold percent for a level selector
  function automatic logic [6:0] level_pct(input logic ov, input logic [1:0] sel);
    case ({ov, sel})
      3'h0: return UV_PCT0;
      3'h1: return UV_PCT1;
      3'h2: return UV_PCT2;
      3'h3: return UV_PCT3;
      3'h4: return OV_PCT0;
      3'h5: return OV_PCT1;
      3'h6: return OV_PCT2;
      default: return OV_PCT3;
    endcase
  endfunction

  // threshold in millivolts from nominal and percent
  function automatic logic [15:0] pct_of(input logic [15:0] nom, input logic [6:0] pct);
    logic [22:0] prod;
    prod = 23'(nom) * 23'(pct);
    return 16'(prod / 23'd100);
  endfunction
endpackage
`default_nettype wire

// >>> design/rvm_channel.sv
// one monitor channel: thresholds, ramp mask and debounce for one regulator
`default_nettype none
module rvm_channel import rvm_pkg::*; (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic tick,
  input wire logic monitor_enable,
  input wire logic reg_on,
  input wire logic [15:0] volt_mv,
  input wire logic [15:0] nominal_mv,
  input wire logic [1:0] undervolt_level_sel,
  input wire logic [1:0] overvolt_level_sel,
  input wire logic [3:0] uv_limit,
  input wire logic [3:0] ov_limit,
  output logic undervolt_status_q,
  output logic overvolt_status_q,
  output logic uv_rise_q,
  output logic ov_rise_q,
  output logic masked_q
);
  logic [3:0] uv_cnt_q, uv_cnt_d; // ticks the undervoltage condition has held
  logic [3:0] ov_cnt_q, ov_cnt_d; // ticks the overvoltage condition has held
  logic masked_d, uv_stat_d, ov_stat_d;

  // thresholds follow the nominal currently programmed
  wire logic [15:0] uv_thr = pct_of(nominal_mv, level_pct(1'b0, undervolt_level_sel));
  wire logic [15:0] ov_thr = pct_of(nominal_mv, level_pct(1'b1, overvolt_level_sel));
  wire logic uv_cond = volt_mv < uv_thr;
  wire logic ov_cond = volt_mv > ov_thr;
  // both checks run only when enabled, powered and past the ramp
  wire logic active = monitor_enable & reg_on & ~masked_q;
  wire logic uv_run = active & uv_cond;
  wire logic ov_run = active & ov_cond;

  // mask from switch-on until the output reaches regulation
  assign masked_d = ~reg_on | (masked_q & uv_cond);

  // counts advance on low-clock ticks; any break restarts them
  assign uv_cnt_d = !uv_run ? 4'h0 : (tick && uv_cnt_q != 4'hF) ? uv_cnt_q + 4'h1 : uv_cnt_q;
  assign ov_cnt_d = !ov_run ? 4'h0 : (tick && ov_cnt_q != 4'hF) ? ov_cnt_q + 4'h1 : ov_cnt_q;

  // status only after the full debounce; disable forces zero
  assign uv_stat_d = uv_run & (uv_cnt_d >= uv_limit);
  assign ov_stat_d = ov_run & (ov_cnt_d >= ov_limit);

  // state registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      uv_cnt_q <= 4'h0;
      ov_cnt_q <= 4'h0;
      masked_q <= 1'b1;
      undervolt_status_q <= 1'b0;
      overvolt_status_q <= 1'b0;
      uv_rise_q <= 1'b0;
      ov_rise_q <= 1'b0;
    end else begin
      uv_cnt_q <= uv_cnt_d;
      ov_cnt_q <= ov_cnt_d;
      masked_q <= masked_d;
      undervolt_status_q <= uv_stat_d;
      overvolt_status_q <= ov_stat_d;
      uv_rise_q <= uv_stat_d & ~undervolt_status_q;
      ov_rise_q <= ov_stat_d & ~overvolt_status_q;
    end
  end

  // checks on this channel
  a_disable_clears: assert property (@(posedge pclk) disable iff (!presetn)
    !monitor_enable |=> !undervolt_status_q && !overvolt_status_q)
    else $error("status stayed set after monitor disable");
  a_mask_blocks: assert property (@(posedge pclk) disable iff (!presetn)
    masked_q |=> !undervolt_status_q && !overvolt_status_q)
    else $error("status set while ramp mask active");
  a_uv_debounced: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(undervolt_status_q) |-> uv_cnt_q >= uv_limit && uv_cnt_q != 4'h0)
    else $error("undervoltage set before debounce time");
  a_ov_debounced: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(overvolt_status_q) |-> ov_cnt_q >= ov_limit && ov_cnt_q != 4'h0)
    else $error("overvoltage set before debounce time");
  a_uv_level: assert property (@(posedge pclk) disable iff (!presetn)
    undervolt_status_q |-> $past(volt_mv) < $past(uv_thr))
    else $error("undervoltage without voltage below threshold");
  a_ov_level: assert property (@(posedge pclk) disable iff (!presetn)
    overvolt_status_q |-> $past(volt_mv) > $past(ov_thr))
    else $error("overvoltage without voltage above threshold");
  c_uv_rise: cover property (@(posedge pclk) disable iff (!presetn) $rose(undervolt_status_q));
  c_ov_rise: cover property (@(posedge pclk) disable iff (!presetn) $rose(overvolt_status_q));
  c_mask_release: cover property (@(posedge pclk) disable iff (!presetn) $fell(masked_q));
endmodule // rvm_channel
`default_nettype wire

// >>> design/rvm_monitor.sv
// top of the regulator voltage monitor: apb registers, tick and seven channels
//
// Function
// - undervoltage codes give 95/93/91/89 percent
// - overvoltage codes give 105/107/109/111 percent
// - thresholds scale with each programmed nominal
// - shared undervoltage debounce 5/15/25/40 us
// - undervoltage debounce resets to code 10
// - shared overvoltage debounce 30/50/80/125 us
// - overvoltage debounce resets to code 00
// - per-regulator enable gates both checks
// - all monitor enables reset to one
// - secure mode requires unlock before enable writes
// - mask monitoring during regulator ramp-up
// - disabling clears both status indicators
// - seven independent channels, five plus two
// - debounce counted on 100 kHz ticks
//
// The register offsets and register access over APB were decided locally.
`default_nettype none
module rvm_monitor import rvm_pkg::*; (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [NUM_CH-1:0] reg_on,
  input wire logic [NUM_CH-1:0][15:0] volt_mv,
  output logic [NUM_CH-1:0] undervolt_status,
  output logic [NUM_CH-1:0] overvolt_status,
  output logic event_pending
);
  // control state
  logic [1:0] undervolt_debounce_sel_q; // shared undervoltage debounce code
  logic [1:0] overvolt_debounce_sel_q; // shared overvoltage debounce code
  logic secure_en_q; // enable writes need an unlock first
  logic armed_q, armed_d; // unlock key seen on the previous write
  logic [NUM_CH-1:0] monitor_enable_q, monitor_enable_d; // per-channel enables

  // per-channel configuration words
  logic [15:0] nominal_q [NUM_CH]; // programmed nominal, millivolts
  logic [1:0] uv_sel_q [NUM_CH]; // undervoltage level per channel
  logic [1:0] ov_sel_q [NUM_CH]; // overvoltage level per channel

  // sticky event record, cleared by writing ones
  logic [NUM_CH-1:0] uv_evt_q, uv_evt_d; // sticky undervoltage events
  logic [NUM_CH-1:0] ov_evt_q, ov_evt_d; // sticky overvoltage events

  // low-clock time base
  logic [8:0] div_q; // pclk divider to the low clock
  logic tick_q; // one pulse per low-clock period
  logic [31:0] rdata_d; // read answer prepared for the access cycle

  // per-channel results gathered from the channel instances
  logic [NUM_CH-1:0] uv_rise; // undervoltage status has just risen
  logic [NUM_CH-1:0] ov_rise; // overvoltage status has just risen
  logic [NUM_CH-1:0] masked; // ramp mask still holding

  // apb phase decode
  wire logic access = psel & penable;
  wire logic first_acc = access & ~pready; // answer is prepared here
  wire logic done = access & pready; // write takes effect here
  wire logic aligned = paddr[1:0] == 2'h0;

  // register hits compare the whole byte address
  wire logic hit_ctrl = paddr == OFS_CTRL;
  wire logic hit_en = paddr == OFS_ENABLE;
  wire logic hit_key = paddr == OFS_KEY;
  wire logic hit_stat = paddr == OFS_STATUS;
  wire logic hit_evt = paddr == OFS_EVENT;
  wire logic hit_cfg = aligned && paddr >= OFS_CHCFG0 && paddr <= OFS_CHCFG6;
  wire logic [2:0] cfg_idx = 3'(paddr[7:2] - OFS_CHCFG0[7:2]);
  // any other address answers with an error
  wire logic addr_ok = hit_ctrl | hit_en | hit_key | hit_stat | hit_evt | hit_cfg;
  // enable write refused while secured and not unlocked
  wire logic en_refused = hit_en & pwrite & secure_en_q & ~armed_q;
  wire logic err_d = ~addr_ok | en_refused;
  // a write lands only when the transfer ends without error
  wire logic wr = done & pwrite & ~pslverr;

  // debounce limits in low-clock ticks, shared by all channels
  wire logic [3:0] uv_limit = uv_db_ticks(undervolt_debounce_sel_q);
  wire logic [3:0] ov_limit = ov_db_ticks(overvolt_debounce_sel_q);

  // unlock arms exactly the next write; any other write disarms
  assign armed_d = (done & pwrite) ? (hit_key & (pwdata == UNLOCK_KEY)) : armed_q;
  assign monitor_enable_d = (wr & hit_en) ? pwdata[NUM_CH-1:0] : monitor_enable_q;

  // events: hardware set wins over write-one-to-clear
  assign uv_evt_d = (uv_evt_q & ~((wr & hit_evt) ? pwdata[NUM_CH-1:0] : '0)) | uv_rise;
  assign ov_evt_d = (ov_evt_q & ~((wr & hit_evt) ? pwdata[STAT_OV_LSB +: NUM_CH] : '0)) | ov_rise;

  // read mux, reserved bits zero
  always_comb begin
    rdata_d = 32'h0000_0000;
    if (hit_ctrl) begin
      // debounce codes and the secure bit
      rdata_d[CTRL_UVDB_LSB +: 2] = undervolt_debounce_sel_q;
      rdata_d[CTRL_OVDB_LSB +: 2] = overvolt_debounce_sel_q;
      rdata_d[CTRL_SECURE_BIT] = secure_en_q;
    end else if (hit_en) begin
      // one enable bit per channel
      rdata_d[NUM_CH-1:0] = monitor_enable_q;
    end else if (hit_stat) begin
      // live status and the ramp masks
      rdata_d[NUM_CH-1:0] = undervolt_status;
      rdata_d[STAT_OV_LSB +: NUM_CH] = overvolt_status;
      rdata_d[STAT_MASK_LSB +: NUM_CH] = masked;
    end else if (hit_evt) begin
      // sticky events
      rdata_d[NUM_CH-1:0] = uv_evt_q;
      rdata_d[STAT_OV_LSB +: NUM_CH] = ov_evt_q;
    end else if (hit_cfg) begin
      // nominal and both level codes of one channel
      rdata_d[15:0] = nominal_q[cfg_idx];
      rdata_d[CFG_UVSEL_LSB +: 2] = uv_sel_q[cfg_idx];
      rdata_d[CFG_OVSEL_LSB +: 2] = ov_sel_q[cfg_idx];
    end
  end

  // apb answer: ready one cycle into the access phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      // answer in the second access cycle, for one cycle only
      pready <= first_acc;
      pslverr <= first_acc & err_d;
      if (first_acc) begin
        prdata <= (pwrite | err_d) ? 32'h0000_0000 : rdata_d;
      end
    end
  end

  // control register and enables
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      undervolt_debounce_sel_q <= UV_DB_RST;
      overvolt_debounce_sel_q <= OV_DB_RST;
      secure_en_q <= 1'b0;
      armed_q <= 1'b0;
      monitor_enable_q <= ENABLE_RST;
    end else begin
      armed_q <= armed_d;
      monitor_enable_q <= monitor_enable_d;
      // an accepted write replaces the whole control word
      if (wr & hit_ctrl) begin
        undervolt_debounce_sel_q <= pwdata[CTRL_UVDB_LSB +: 2];
        overvolt_debounce_sel_q <= pwdata[CTRL_OVDB_LSB +: 2];
        secure_en_q <= pwdata[CTRL_SECURE_BIT];
      end
    end
  end

  // per-channel nominal and level selectors
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < NUM_CH; i++) begin
        nominal_q[i] <= NOMINAL_RST;
        uv_sel_q[i] <= 2'h0;
        ov_sel_q[i] <= 2'h0;
      end
    end else if (wr & hit_cfg) begin
      // only the addressed channel changes
      nominal_q[cfg_idx] <= pwdata[15:0];
      uv_sel_q[cfg_idx] <= pwdata[CFG_UVSEL_LSB +: 2];
      ov_sel_q[cfg_idx] <= pwdata[CFG_OVSEL_LSB +: 2];
    end
  end

  // events and the pending flag
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      uv_evt_q <= '0;
      ov_evt_q <= '0;
      event_pending <= 1'b0;
    end else begin
      uv_evt_q <= uv_evt_d;
      ov_evt_q <= ov_evt_d;
      // pending rises with the event it reports
      event_pending <= |{uv_evt_d, ov_evt_d};
    end
  end

  // low-clock tick from pclk, 100 kHz
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_q <= 9'h000;
      tick_q <= 1'b0;
    end else begin
      // the divider wraps once per low-clock period
      div_q <= (div_q == TICK_DIV) ? 9'h000 : div_q + 9'h001;
      tick_q <= div_q == TICK_DIV;
    end
  end

  // seven independent channels: 0..4 switchers, 5..6 linear
  for (genvar g = 0; g < NUM_CH; g++) begin : g_ch
    // debounce limits and the tick are shared, all else is per channel
    rvm_channel u_ch (
      .pclk(pclk),
      .presetn(presetn),
      .tick(tick_q),
      .monitor_enable(monitor_enable_q[g]),
      .reg_on(reg_on[g]),
      .volt_mv(volt_mv[g]),
      .nominal_mv(nominal_q[g]),
      .undervolt_level_sel(uv_sel_q[g]),
      .overvolt_level_sel(ov_sel_q[g]),
      .uv_limit(uv_limit),
      .ov_limit(ov_limit),
      .undervolt_status_q(undervolt_status[g]),
      .overvolt_status_q(overvolt_status[g]),
      .uv_rise_q(uv_rise[g]),
      .ov_rise_q(ov_rise[g]),
      .masked_q(masked[g])
    );
  end

  // checks on the register side
  a_secure_guard: assert property (@(posedge pclk) disable iff (!presetn)
    (done && pwrite && hit_en && secure_en_q && !armed_q) |=> monitor_enable_q == $past(monitor_enable_q))
    else $error("enable changed without unlock in secure mode");
  a_event_latch: assert property (@(posedge pclk) disable iff (!presetn)
    |uv_rise |=> (uv_evt_q & $past(uv_rise)) == $past(uv_rise) && event_pending)
    else $error("undervoltage event not latched");
  a_tick_period: assert property (@(posedge pclk) disable iff (!presetn)
    tick_q |=> !tick_q [*8])
    else $error("low clock tick too frequent");
  a_ready_pulse: assert property (@(posedge pclk) disable iff (!presetn)
    first_acc |=> pready ##1 !pready)
    else $error("apb ready not a single cycle");

  // bus answer checks
  a_err_needs_ready: assert property (@(posedge pclk) disable iff (!presetn)
    pslverr |-> pready)
    else $error("apb error without ready");

  a_ready_in_access: assert property (@(posedge pclk) disable iff (!presetn)
    pready |-> psel && penable)
    else $error("apb ready outside an access");

  a_write_reads_zero: assert property (@(posedge pclk) disable iff (!presetn)
    first_acc && pwrite |=> prdata == 32'h0000_0000)
    else $error("read data not zero on a write");

  a_unmapped_error: assert property (@(posedge pclk) disable iff (!presetn)
    first_acc && !addr_ok |=> pslverr)
    else $error("unmapped address without error");

  // register write checks
  a_refused_error: assert property (@(posedge pclk) disable iff (!presetn)
    first_acc && en_refused |=> pslverr)
    else $error("refused enable write without error");

  a_disarm_after_write: assert property (@(posedge pclk) disable iff (!presetn)
    done && pwrite && !hit_key |=> !armed_q)
    else $error("unlock survived another write");

  a_secure_lands: assert property (@(posedge pclk) disable iff (!presetn)
    wr && hit_ctrl |=> secure_en_q == $past(pwdata[CTRL_SECURE_BIT]))
    else $error("secure bit write lost");

  a_enable_lands: assert property (@(posedge pclk) disable iff (!presetn)
    wr && hit_en |=> monitor_enable_q == $past(pwdata[NUM_CH-1:0]))
    else $error("enable write lost");

  a_uvdb_lands: assert property (@(posedge pclk) disable iff (!presetn)
    wr && hit_ctrl |=> undervolt_debounce_sel_q == $past(pwdata[CTRL_UVDB_LSB +: 2]))
    else $error("undervoltage debounce write lost");

  a_ovdb_lands: assert property (@(posedge pclk) disable iff (!presetn)
    wr && hit_ctrl |=> overvolt_debounce_sel_q == $past(pwdata[CTRL_OVDB_LSB +: 2]))
    else $error("overvoltage debounce write lost");

  a_nominal_lands: assert property (@(posedge pclk) disable iff (!presetn)
    wr && hit_cfg |=> nominal_q[$past(cfg_idx)] == $past(pwdata[15:0]))
    else $error("nominal write lost");

  a_uvsel_lands: assert property (@(posedge pclk) disable iff (!presetn)
    wr && hit_cfg |=> uv_sel_q[$past(cfg_idx)] == $past(pwdata[CFG_UVSEL_LSB +: 2]))
    else $error("undervoltage level write lost");

  // event and time base checks
  a_ov_event_latch: assert property (@(posedge pclk) disable iff (!presetn)
    |ov_rise |=> (ov_evt_q & $past(ov_rise)) == $past(ov_rise) && event_pending)
    else $error("overvoltage event not latched");

  a_tick_source: assert property (@(posedge pclk) disable iff (!presetn)
    tick_q |-> $past(div_q) == TICK_DIV)
    else $error("low clock tick off the divider wrap");

  // scenario covers
  c_secure_write: cover property (@(posedge pclk) disable iff (!presetn) wr && hit_en && secure_en_q);
  c_refused: cover property (@(posedge pclk) disable iff (!presetn) done && en_refused);
endmodule // rvm_monitor
`default_nettype wire

// >>> tb/rvm_monitor_tb.sv
// self-checking testbench for the regulator voltage monitor, driven over apb
`default_nettype none
module rvm_monitor_tb import rvm_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk; // bus clock, 50 MHz
  logic presetn; // active-low reset
  logic psel, penable, pwrite; // apb request
  logic [7:0] paddr; // apb byte address
  logic [31:0] pwdata; // apb write data
  logic [31:0] prdata; // apb read data
  logic pready, pslverr; // apb answer
  logic [NUM_CH-1:0] reg_on; // regulator switched on
  logic [NUM_CH-1:0][15:0] volt_mv; // measured output per channel
  logic [NUM_CH-1:0] undervolt_status, overvolt_status; // live status
  logic event_pending; // any sticky event
  int miscompares = 0; // mismatches seen
  int compares = 0; // comparisons made
  int uvp[4] = '{95, 93, 91, 89}; // undervoltage percent per code
  int ovp[4] = '{105, 107, 109, 111}; // overvoltage percent per code
  int uvus[4] = '{5, 15, 25, 40}; // undervoltage debounce in us
  int ovus[4] = '{30, 50, 80, 125}; // overvoltage debounce in us
  logic [31:0] rd; // last read data
  logic er; // last error flag
  int n; // cycles waited
  rvm_monitor dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .reg_on(reg_on),
    .volt_mv(volt_mv), .undervolt_status(undervolt_status), .overvolt_status(overvolt_status),
    .event_pending(event_pending));
  // free-running bus clock
  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end
  // nominal of each channel, all different so thresholds differ
  function automatic int nomv(input int ch);
    return 1000 + 350 * ch;
  endfunction
  // expected thresholds, floor of nominal times percent over 100
  function automatic int uvthr(input int ch);
    return nomv(ch) * uvp[ch % 4] / 100;
  endfunction
  function automatic int ovthr(input int ch);
    return nomv(ch) * ovp[(ch + 1) % 4] / 100;
  endfunction
  // compare seen against expected and report a mismatch
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // one apb transfer: setup, access held until pready at a rising edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    // pready, data and error are taken as sampled at the rising edge
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    rd = prdata;
    er = pslverr;
    if (k >= 20) chk("pready", 32'h0, 32'h1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // read a register and compare data and error flag
  task automatic rd_chk(input string name, input logic [7:0] a, input logic [31:0] exp, input logic experr);
    apb(1'b0, a, 32'h0);
    chk(name, rd, exp);
    chk({name, "_err"}, 32'(er), 32'(experr));
  endtask
  // drive one channel voltage at a rising edge
  task automatic setv(input int ch, input int v);
    @(posedge pclk);
    volt_mv[ch] <= 16'(v);
  endtask
  // wait for a status bit under a bound, cycles counted into n
  task automatic wait_st(input logic ov, input int ch);
    n = 0;
    while (((ov ? overvolt_status[ch] : undervolt_status[ch]) !== 1'b1) && n < 8000) begin
      @(negedge pclk);
      n++;
    end
  endtask
  // print counts and verdict, then end the run
  task automatic results();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // hang guard
  initial begin
    repeat (90000) @(posedge pclk);
    miscompares++;
    results();
  end
  // main sequence
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    reg_on = '0;
    volt_mv = '0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    // reset values, ramp mask and an unmapped place
    rd_chk("ctrl_rst", OFS_CTRL, 32'h0000_0002, 1'b0);
    rd_chk("enable_rst", OFS_ENABLE, 32'h0000_007F, 1'b0);
    rd_chk("status_rst", OFS_STATUS, 32'h007F_0000, 1'b0);
    rd_chk("unmapped", 8'h44, 32'h0, 1'b1);
    rd_chk("cfg_rst", OFS_CHCFG6, 32'(NOMINAL_RST), 1'b0);
    $display("test reset done");
    // configure channels; ch6 switched on but below its threshold stays masked
    apb(1'b1, OFS_CTRL, 32'h0);
    for (int c = 0; c < NUM_CH; c++) begin
      apb(1'b1, OFS_CHCFG0 + 8'(4 * c), 32'(nomv(c)) | 32'(c % 4) << 16 | 32'((c + 1) % 4) << 18);
    end
    rd_chk("cfg_back", OFS_CHCFG0 + 8'h08, 32'(nomv(2)) | 32'h000E_0000, 1'b0);
    @(posedge pclk);
    for (int c = 0; c < NUM_CH - 1; c++) volt_mv[c] <= 16'(uvthr(c));
    reg_on <= 7'h7F;
    repeat (1200) @(negedge pclk);
    rd_chk("status_ramp", OFS_STATUS, 32'h0040_0000, 1'b0);
    chk("uv_ramp", 32'(undervolt_status), 32'h0);
    setv(6, uvthr(6));
    repeat (4) @(negedge pclk);
    rd_chk("status_up", OFS_STATUS, 32'h0, 1'b0);
    $display("test ramp mask done");
    // per-channel thresholds at their exact boundaries
    for (int c = 0; c < NUM_CH; c++) begin
      setv(c, uvthr(c) - 1);
      wait_st(1'b0, c);
      chk("uv_trip", 32'(undervolt_status), 32'(1) << c);
      setv(c, ovthr(c));
      repeat (1700) @(negedge pclk);
      chk("ov_edge", 32'({overvolt_status, undervolt_status}), 32'h0);
      setv(c, ovthr(c) + 1);
      wait_st(1'b1, c);
      chk("ov_trip", 32'(overvolt_status), 32'(1) << c);
      setv(c, nomv(c));
    end
    $display("test thresholds done");
    // debounce length for every code, measured in cycles of 10 us ticks
    for (int s = 0; s < 4; s++) begin
      apb(1'b1, OFS_CTRL, 32'(s) | 32'(s) << 2);
      setv(0, uvthr(0) - 1);
      wait_st(1'b0, 0);
      chk("uv_db", 32'(n >= ((uvus[s] + 9) / 10 - 1) * 500 && n <= (uvus[s] + 9) / 10 * 500 + 8), 32'h1);
      setv(0, ovthr(0) + 1);
      wait_st(1'b1, 0);
      chk("ov_db", 32'(n >= ((ovus[s] + 9) / 10 - 1) * 500 && n <= (ovus[s] + 9) / 10 * 500 + 8), 32'h1);
      setv(0, nomv(0));
      repeat (4) @(negedge pclk);
    end
    // two short dips with a gap between must not add up
    setv(0, uvthr(0) - 1);
    repeat (1400) @(negedge pclk);
    setv(0, nomv(0));
    setv(0, uvthr(0) - 1);
    repeat (1400) @(negedge pclk);
    chk("uv_glitch", 32'(undervolt_status), 32'h0);
    setv(0, nomv(0));
    $display("test debounce done");
    // events: clear all, raise one, clear it
    apb(1'b1, OFS_CTRL, 32'h0);
    apb(1'b1, OFS_EVENT, 32'h0000_7F7F);
    rd_chk("event_clr", OFS_EVENT, 32'h0, 1'b0);
    chk("pending_clr", 32'(event_pending), 32'h0);
    setv(0, uvthr(0) - 1);
    wait_st(1'b0, 0);
    repeat (3) @(negedge pclk);
    rd_chk("event_set", OFS_EVENT, 32'h1, 1'b0);
    chk("pending_set", 32'(event_pending), 32'h1);
    apb(1'b1, OFS_EVENT, 32'h1);
    rd_chk("event_w1c", OFS_EVENT, 32'h0, 1'b0);
    $display("test events done");
    // disabling clears both indicators and keeps them clear
    setv(1, ovthr(1) + 1);
    wait_st(1'b1, 1);
    rd_chk("event_ov", OFS_EVENT, 32'h0000_0200, 1'b0);
    apb(1'b1, OFS_ENABLE, 32'h0000_007C);
    repeat (2) @(negedge pclk);
    chk("dis_clear", 32'({undervolt_status[0], overvolt_status[1]}), 32'h0);
    repeat (2000) @(negedge pclk);
    chk("dis_hold", 32'({undervolt_status[0], overvolt_status[1]}), 32'h0);
    setv(0, nomv(0));
    setv(1, nomv(1));
    apb(1'b1, OFS_ENABLE, 32'h0000_007F);
    $display("test disable done");
    // secure mode: plain and disarmed enable writes refused, armed one taken
    apb(1'b1, OFS_CTRL, 32'h0000_0100);
    rd_chk("ctrl_sec", OFS_CTRL, 32'h0000_0100, 1'b0);
    apb(1'b1, OFS_ENABLE, 32'h0);
    chk("sec_refuse", 32'(er), 32'h1);
    apb(1'b1, OFS_KEY, UNLOCK_KEY);
    apb(1'b1, OFS_KEY, 32'h0000_1234);
    apb(1'b1, OFS_ENABLE, 32'h0);
    chk("sec_disarm", 32'(er), 32'h1);
    rd_chk("en_kept", OFS_ENABLE, 32'h0000_007F, 1'b0);
    apb(1'b1, OFS_KEY, UNLOCK_KEY);
    apb(1'b1, OFS_ENABLE, 32'h0000_0055);
    chk("sec_accept", 32'(er), 32'h0);
    rd_chk("en_new", OFS_ENABLE, 32'h0000_0055, 1'b0);
    $display("test secure done");
    results();
  end
endmodule // rvm_monitor_tb
`default_nettype wire
